// ===== hdl/sem_pkg.sv
package sem_pkg;

  localparam int NUM_MOD = 11;
  localparam int IDX_BUCKBOOST = 0;
  localparam int IDX_BUCK_A = 1;
  localparam int IDX_BUCK_B = 2;
  localparam int NUM_CONV = 3;
  localparam int IDX_HCLDO = 9;
  localparam int IDX_RETENTION = 10;
  localparam int NUM_PINS = 3;

  // Enable register field layout
  localparam int ENA_W = 6;
  localparam int FORCE_BIT = 0;
  localparam int GPIO_LSB = 1;
  localparam int PHASE_LSB = 4;
  localparam int PHASE_W = 2;
  localparam int DEB_W = 2;

  localparam logic [NUM_MOD-1:0] MONITORED = 11'h3ff;
  localparam logic [NUM_MOD-1:0] LDO_MASK = 11'h7f8;

  // Register byte offsets
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_ENA_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STBY = 12'h040;
  localparam logic [ADDR_W-1:0] OFS_DEB = 12'h044;
  localparam logic [ADDR_W-1:0] OFS_EN_STAT = 12'h048;
  localparam logic [ADDR_W-1:0] OFS_PWROK_STAT = 12'h04c;
  localparam logic [ADDR_W-1:0] OFS_FAIL_STAT = 12'h050;
  localparam int WORD_SHIFT = 2;

  localparam logic [DEB_W-1:0] DEB_RST = 2'h3;
  localparam logic [NUM_MOD-1:0][ENA_W-1:0] ENA_RST_DEFAULT = '0;
  localparam logic [NUM_MOD-1:0] STBY_RST_DEFAULT = 11'h000;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int NS_PER_MS = 1000000;
  localparam int DEB1_MS = 1;
  localparam int DEB2_MS = 10;
  localparam int DEB3_MS = 100;
  localparam int MASK_MS = 100;
  localparam int DEB1_CYC = (DEB1_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB2_CYC = (DEB2_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB3_CYC = (DEB3_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MASK_CYC = (MASK_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 20;

  typedef enum logic [1:0] {
    SEQUENCE_PHASE_ONE,
    SEQUENCE_PHASE_TWO,
    SEQUENCE_PHASE_THREE,
    SEQUENCE_PHASE_FOUR
  } sem_phase_type;

  typedef enum logic [1:0] {
    DEB_NONE,
    DEB_1MS,
    DEB_10MS,
    DEB_100MS
  } sem_deb_type;

  typedef enum logic [1:0] {
    PST_NOPOWER,
    PST_STANDBY,
    PST_ACTIVE,
    PST_OTHER
  } sem_pstate_type;

  // Power state and sequencing progress from the state controller
  typedef struct packed {
    sem_pstate_type state;
    logic busy;
    logic up;
    sem_phase_type phase;
  } sem_seq_ctrl_type;

endpackage

// ===== hdl/sem_supply_ctrl.sv
`timescale 1ns/1ps
module sem_supply_ctrl #(
  parameter int unsigned DEB1_CYC = sem_pkg::DEB1_CYC,
  parameter int unsigned DEB2_CYC = sem_pkg::DEB2_CYC,
  parameter int unsigned DEB3_CYC = sem_pkg::DEB3_CYC,
  parameter int unsigned MASK_CYC = sem_pkg::MASK_CYC,
  parameter logic [sem_pkg::NUM_MOD-1:0][sem_pkg::ENA_W-1:0] ENA_RST = sem_pkg::ENA_RST_DEFAULT,
  parameter logic [sem_pkg::NUM_MOD-1:0] STBY_RST = sem_pkg::STBY_RST_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sem_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sem_pkg::sem_seq_ctrl_type seq_ctrl,
  input wire logic [sem_pkg::NUM_PINS-1:0] supply_enable_pin,
  input wire logic [sem_pkg::NUM_MOD-1:0] pwrok,
  output logic [sem_pkg::NUM_MOD-1:0] supply_enable,
  output logic [sem_pkg::NUM_MOD-1:0] pwr_fail,
  output logic [sem_pkg::NUM_MOD-1:0] pwr_fail_event
);

  localparam int N = sem_pkg::NUM_MOD;
  localparam int CW = sem_pkg::CNT_W;
  localparam int AW = sem_pkg::ADDR_W;

  typedef struct packed {
    logic [N-1:0][sem_pkg::ENA_W-1:0] ena;
    logic [N-1:0] stby;
    logic [N-1:0][sem_pkg::DEB_W-1:0] deb;
    logic [N-1:0] en;
    logic [N-1:0][CW-1:0] mask_cnt;
    logic [N-1:0][CW-1:0] deb_cnt;
    logic [N-1:0] filt;
    logic [N-1:0] evt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sem_state_type;

  // Control bits come up at the variant constants
  localparam sem_state_type Q_RST = '{
    ena: ENA_RST,
    stby: STBY_RST,
    deb: {N{sem_pkg::DEB_RST}},
    default: '0
  };

  sem_state_type q_q;
  sem_state_type q_d;
  logic [N-1:0] want;

  // Per-module enable request from the current control bits
  for (genvar i = 0; i < N; i++) begin : g_req
    logic [sem_pkg::PHASE_W-1:0] ph;
    logic act_req;
    logic in_phase;
    logic active_on;
    assign ph = q_q.ena[i][sem_pkg::PHASE_LSB +: sem_pkg::PHASE_W];
    assign act_req = q_q.ena[i][sem_pkg::FORCE_BIT] |
      (|(q_q.ena[i][sem_pkg::GPIO_LSB +: sem_pkg::NUM_PINS] & supply_enable_pin));
    // Code 00 is phase one for every module, buckboost included
    assign in_phase = !seq_ctrl.busy ||
      (seq_ctrl.up ? (ph <= seq_ctrl.phase) : (ph < seq_ctrl.phase));
    assign active_on = (seq_ctrl.state == sem_pkg::PST_ACTIVE) && act_req && in_phase;
    if (i < sem_pkg::NUM_CONV) begin : g_conv
      assign want[i] = active_on;
    end else begin : g_ldo
      assign want[i] = active_on || ((seq_ctrl.state == sem_pkg::PST_STANDBY) && q_q.stby[i]);
    end
  end

  function automatic logic [CW-1:0] deb_limit(input logic [sem_pkg::DEB_W-1:0] sel);
    unique case (sem_pkg::sem_deb_type'(sel))
      sem_pkg::DEB_NONE: return '0;
      sem_pkg::DEB_1MS: return CW'(DEB1_CYC);
      sem_pkg::DEB_10MS: return CW'(DEB2_CYC);
      sem_pkg::DEB_100MS: return CW'(DEB3_CYC);
    endcase
  endfunction

  logic ena_hit;
  logic [AW-1:0] ena_idx;
  logic [AW-1:0] word_ofs;
  assign word_ofs = paddr - sem_pkg::OFS_ENA_BASE;
  assign ena_idx = word_ofs >> sem_pkg::WORD_SHIFT;
  assign ena_hit = (paddr >= sem_pkg::OFS_ENA_BASE) && (ena_idx < AW'(N)) && (paddr[1:0] == 2'h0);

  always_comb begin
    logic [N-1:0] en_next;
    logic raw;
    logic [CW-1:0] lim;
    en_next = want;
    raw = 1'b0;
    lim = '0;
    q_d = q_q;
    q_d.pready = 1'b0;
    q_d.pslverr = 1'b0;
    q_d.evt = '0;

    // Setup phase: decode and latch the answer for the access phase
    if (psel && !penable) begin
      q_d.pready = 1'b1;
      q_d.prdata = '0;
      if (ena_hit) begin
        q_d.prdata = 32'(q_q.ena[ena_idx[3:0]]);
      end else if (paddr == sem_pkg::OFS_STBY) begin
        q_d.prdata = 32'(q_q.stby);
      end else if (paddr == sem_pkg::OFS_DEB) begin
        q_d.prdata = 32'(q_q.deb);
      end else if (paddr == sem_pkg::OFS_EN_STAT) begin
        q_d.prdata = 32'(q_q.en);
      end else if (paddr == sem_pkg::OFS_PWROK_STAT) begin
        q_d.prdata = 32'(pwrok & sem_pkg::MONITORED);
      end else if (paddr == sem_pkg::OFS_FAIL_STAT) begin
        q_d.prdata = 32'(q_q.filt);
      end else begin
        q_d.pslverr = 1'b1;
      end
    end

    // Writes land on the access edge only
    if (psel && penable && q_q.pready && pwrite && !q_q.pslverr) begin
      if (ena_hit) begin
        q_d.ena[ena_idx[3:0]] = pwdata[sem_pkg::ENA_W-1:0];
      end else if (paddr == sem_pkg::OFS_STBY) begin
        q_d.stby = pwdata[N-1:0] & sem_pkg::LDO_MASK;
      end else if (paddr == sem_pkg::OFS_DEB) begin
        q_d.deb = pwdata[N*sem_pkg::DEB_W-1:0];
      end
    end

    // Retention LDO yields to buck B, which feeds the same rail
    if (want[sem_pkg::IDX_BUCK_B]) begin
      en_next[sem_pkg::IDX_RETENTION] = 1'b0;
    end

    for (int i = 0; i < N; i++) begin
      q_d.en[i] = en_next[i];
      if (en_next[i] && !q_q.en[i]) begin
        q_d.mask_cnt[i] = CW'(MASK_CYC);
      end else if (q_q.mask_cnt[i] != '0) begin
        q_d.mask_cnt[i] = q_q.mask_cnt[i] - CW'(1);
      end
      raw = q_q.en[i] && !pwrok[i] && (q_q.mask_cnt[i] == '0) && sem_pkg::MONITORED[i];
      lim = deb_limit(q_q.deb[i]);
      if (!q_q.en[i]) begin
        q_d.filt[i] = 1'b0;
        q_d.deb_cnt[i] = '0;
      end else if (raw == q_q.filt[i]) begin
        q_d.deb_cnt[i] = '0;
      end else if (q_q.deb_cnt[i] >= lim) begin
        q_d.filt[i] = raw;
        q_d.deb_cnt[i] = '0;
        q_d.evt[i] = raw;
      end else begin
        q_d.deb_cnt[i] = q_q.deb_cnt[i] + CW'(1);
      end
    end
    // A failure never feeds back into en_next; switching off is the host's call
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_q <= Q_RST;
    end else begin
      q_q <= q_d;
    end
  end

  assign prdata = q_q.prdata;
  assign pready = q_q.pready;
  assign pslverr = q_q.pslverr;
  assign supply_enable = q_q.en;
  assign pwr_fail = q_q.filt;
  assign pwr_fail_event = q_q.evt;

endmodule

// ===== tb/sem_supply_checker.sv
`timescale 1ns/1ps
module sem_supply_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire sem_pkg::sem_seq_ctrl_type seq_ctrl,
  input wire logic [sem_pkg::NUM_MOD-1:0] supply_enable,
  input wire logic [sem_pkg::NUM_MOD-1:0] pwr_fail,
  input wire logic [sem_pkg::NUM_MOD-1:0] pwr_fail_event
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  conv_active_a: assert property (
    |supply_enable[2:0] |-> $past(seq_ctrl.state) == sem_pkg::PST_ACTIVE) else $error("Converter on outside active");
  ret_gate_a: assert property (
    !(supply_enable[2] && supply_enable[10])) else $error("Retention on with buck b");
  ret_nofail_a: assert property (
    !pwr_fail[10] && !pwr_fail_event[10]) else $error("Retention reported failing");
  fail_event_a: assert property (
    pwr_fail_event == (pwr_fail & ~$past(pwr_fail))) else $error("Event not on fail edge");
  // Either edge counts, as the enable may drop on the very edge the filter flips
  fail_enabled_a: assert property (
    (pwr_fail & ~$past(pwr_fail) & ~(supply_enable | $past(supply_enable))) == '0) else $error("Fail while off");
  startup_mask_a: assert property (
    $rose(supply_enable[0]) |-> !pwr_fail[0] [*8]) else $error("Fail inside start mask");
  ready_timing_a: assert property (
    pready == $past(psel && !penable)) else $error("Ready not in access cycle");
  err_ready_a: assert property (
    pslverr |-> pready) else $error("Error without ready");
endmodule
bind sem_supply_ctrl sem_supply_checker sem_supply_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .seq_ctrl(seq_ctrl), .supply_enable(supply_enable),
  .pwr_fail(pwr_fail), .pwr_fail_event(pwr_fail_event));

// ===== tb/sem_supply_model.sv
`timescale 1ns/1ps
module sem_supply_model (
  input wire logic [10:0] supply_enable,
  input wire logic fault,
  output logic [10:0] pwrok
);
  // Good only while enabled; a commanded fault drags the buck-boost output low
  assign pwrok = supply_enable & ~{10'h000, fault};
endmodule

// ===== tb/supply_enable_and_fail_monitor_bench.sv
`timescale 1ns/1ps
module supply_enable_and_fail_monitor_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, flt = 0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr;
  sem_pkg::sem_seq_ctrl_type seq_ctrl = '0;
  logic [2:0] pins = '0;
  logic [10:0] pwrok, se, pf, pfe;
  int n_errors = 0, checks = 0;
  int lim[4] = '{0, 4, 8, 16};
  always #50 pclk = ~pclk;
  sem_supply_ctrl #(.DEB1_CYC(4), .DEB2_CYC(8), .DEB3_CYC(16), .MASK_CYC(20)) sem_supply_ctrl_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .seq_ctrl(seq_ctrl), .supply_enable_pin(pins),
    .pwrok(pwrok), .supply_enable(se), .pwr_fail(pf), .pwr_fail_event(pfe));
  sem_supply_model sem_supply_model_inst (.supply_enable(se), .fault(flt), .pwrok(pwrok));
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk(0, 1);
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  // Two edges: one for the input to land, one for the registered enable
  task automatic st(input logic [5:0] s, input logic [10:0] e);
    seq_ctrl <= sem_pkg::sem_seq_ctrl_type'(s);
    repeat (2) @(posedge pclk);
    chk(se, e);
  endtask
  task automatic wait_pf(input logic e, input int m);
    int k;
    for (k = 0; k < m && pf[0] !== e; k++) @(posedge pclk);
    if (k == m) begin
      chk(0, 1);
      end_of_test();
    end
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h044, 0);
    chk(rd, 32'h003f_ffff);
    apb(0, 12'h000, 0);
    chk(rd, 0);
    apb(0, 12'h100, 0);
    chk(err, 1);
    chk(rd, 0);
    for (int p = 0; p < 4; p++) begin
      apb(1, 12'h000, 32'(16 * p + 1));
      st({sem_pkg::PST_ACTIVE, 2'b11, 2'(p)}, 11'h001);
      st({sem_pkg::PST_ACTIVE, 2'b10, 2'(p)}, 11'h000);
      if (p > 0) st({sem_pkg::PST_ACTIVE, 2'b11, 2'(p - 1)}, 11'h000);
    end
    apb(1, 12'h000, 0);
    apb(1, 12'h008, 32'h0000_0004);
    apb(1, 12'h028, 32'h0000_0001);
    st({sem_pkg::PST_ACTIVE, 4'b0100}, 11'h400);
    pins <= 3'b010;
    st({sem_pkg::PST_ACTIVE, 4'b0100}, 11'h004);
    pins <= 3'b101;
    st({sem_pkg::PST_ACTIVE, 4'b0100}, 11'h400);
    apb(1, 12'h040, 32'h0000_0400);
    pins <= 3'b010;
    st({sem_pkg::PST_STANDBY, 4'b0100}, 11'h400);
    apb(1, 12'h028, 0);
    pins <= 3'b000;
    apb(1, 12'h044, 32'h000f_fffc);
    flt <= 1;
    apb(1, 12'h000, 32'h0000_0001);
    st({sem_pkg::PST_ACTIVE, 4'b0100}, 11'h001);
    repeat (15) @(posedge pclk);
    chk(pf[0], 0);
    wait_pf(1, 30);
    chk(se[0], 1);
    flt <= 0;
    wait_pf(0, 30);
    for (int c = 0; c < 4; c++) begin
      apb(1, 12'h044, 32'h000f_fffc | 32'(c));
      flt <= 1;
      repeat (lim[c] + 1) @(posedge pclk);
      chk(pf[0], 0);
      @(posedge pclk);
      chk({pf[0], pfe[0]}, 2'b11);
      flt <= 0;
      repeat (lim[c] + 1) @(posedge pclk);
      chk(pf[0], 1);
      wait_pf(0, 3);
    end
    apb(0, 12'h04c, 0);
    chk(rd, 32'h0000_0001);
    flt <= 1;
    wait_pf(1, 30);
    apb(0, 12'h050, 0);
    chk(rd, 32'h0000_0001);
    apb(0, 12'h048, 0);
    chk(rd, 32'h0000_0001);
    // Host reacts to the failure by switching the supply off
    apb(1, 12'h000, 0);
    repeat (2) @(posedge pclk);
    chk({se[0], pf[0]}, 2'b00);
    flt <= 0;
    apb(1, 12'h040, 32'h0000_07ff);
    apb(0, 12'h040, 0);
    chk(rd, 32'h0000_07f8);
    // Mid-run reset must bring the control bits back to their reset values
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk(se, 11'h000);
    apb(0, 12'h040, 0);
    chk(rd, 0);
    apb(0, 12'h044, 0);
    chk(rd, 32'h003f_ffff);
    end_of_test();
  end
endmodule
